// file: rtl/qio_mem.sv
`timescale 1ns/1ns
module qio_mem
  import qio_pkg::*;
(
  input wire logic clk,
  qio_mem_if.mem bus
);

  // ************************************************************
  // Array storage
  // ************************************************************
  // Loaded on clk, read asynchronously by the link side; load only while no frame runs
  logic [7:0] cells [QIO_MEM_DEPTH];

  always_ff @(posedge clk)
  begin
    if (bus.wr_en)
    begin
      cells[bus.wr_addr] <= bus.wr_data;
    end
  end

  assign bus.rd_data = cells[bus.rd_addr];

endmodule : qio_mem

// file: rtl/qio_mem_if.sv
`timescale 1ns/1ns
interface qio_mem_if;
  import qio_pkg::*;
  logic wr_en;
  logic [QIO_MEM_ADDR_W-1:0] wr_addr;
  logic [7:0] wr_data;
  logic [QIO_MEM_ADDR_W-1:0] rd_addr;
  logic [7:0] rd_data;
  modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : qio_mem_if

// file: rtl/qio_pkg.sv
package qio_pkg;

  // ************************************************************
  // Instruction and mode encodings
  // ************************************************************
  localparam logic [7:0] QIO_CMD_QUAD_IO_READ = 8'hEB;
  localparam logic [7:0] QIO_CMD_QUAD_IO_READ_WIDE_ADDR = 8'hEC;
  localparam logic [3:0] QIO_MODE_CONT_NIBBLE = 4'hA;

  // ************************************************************
  // Phase lengths in serial clock cycles
  // ************************************************************
  localparam logic [3:0] QIO_CMD_CYCLES = 4'h8;
  localparam logic [3:0] QIO_ADDR_CYCLES_3B = 4'h6;
  localparam logic [3:0] QIO_ADDR_CYCLES_4B = 4'h8;
  localparam logic [3:0] QIO_MODE_CYCLES = 4'h2;

  // Dummy cycles per latency code
  localparam logic [3:0] QIO_DUMMY_LC00 = 4'h4;
  localparam logic [3:0] QIO_DUMMY_LC01 = 4'h3;
  localparam logic [3:0] QIO_DUMMY_LC10 = 4'h2;
  localparam logic [3:0] QIO_DUMMY_LC11 = 4'h1;

  // ************************************************************
  // Array geometry and configuration bit positions
  // ************************************************************
  localparam int QIO_MEM_ADDR_W = 10;
  localparam int QIO_MEM_DEPTH = 1024;
  localparam int QIO_CFG_QUAD_BIT = 1;
  localparam int QIO_CFG_LC_LSB = 6;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [31:0] QIO_ADDR_RST = 32'h0000_0000;
  localparam logic [7:0] QIO_CMD_RST = 8'h00;
  localparam logic [3:0] QIO_CNT_RST = 4'h0;
  localparam logic [3:0] QIO_NIBBLE_RST = 4'h0;

  typedef enum logic [2:0] {
    QIO_IDLE = 3'b000,
    QIO_CMD = 3'b001,
    QIO_ADDR = 3'b010,
    QIO_MODE = 3'b011,
    QIO_DUMMY = 3'b100,
    QIO_DATA = 3'b101,
    QIO_IGNORE = 3'b110
  } qio_phase_e;

endpackage : qio_pkg

// file: rtl/qio_read_top.sv
`timescale 1ns/1ns
// Operation
// - Command EBh with four-byte select clear takes a three-byte address.
// - Command EBh with four-byte select set takes a four-byte address.
// - Command ECh always takes a four-byte address.
// - Address arrives four bits per serial clock on the four data lines.
// - Quad read command accepted only while the quad enable configuration bit is one; continuous-mode frames read without checking it.
// - Dummy cycles after mode cycles, count taken from the latency code.
// - Data lines are ignored during dummy cycles and may float.
// - Read data leaves one nibble per clock, changing on falling edges.
// - Any start byte; address increments after each full byte shifted out.
// - Past the top address the counter wraps to zero and data continues.
// - Mode field takes two cycles after the address, part of the latency.
// - Upper mode nibble decides continuous mode; lower nibble is ignored.
// - Mode Axh keeps continuous mode; next frame starts with the address.
// - Any other mode value leaves continuous mode; it clears at the first rising edge of the frame.
// - A short frame without valid instruction leaves continuous mode.
module qio_read_top
  import qio_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic [3:0] quad_data_in,
  output logic [3:0] quad_data_out,
  output logic [3:0] quad_data_oe_n,
  input wire logic [7:0] first_configuration_register,
  input wire logic four_byte_address_select,
  input wire logic mem_load_en,
  input wire logic [QIO_MEM_ADDR_W-1:0] mem_load_addr,
  input wire logic [7:0] mem_load_data,
  output logic frame_active,
  output logic continuous_mode
);

  // ************************************************************
  // Array and its carrier
  // ************************************************************
  qio_mem_if mem_bus ();

  qio_mem u_mem (
    .clk(clk),
    .bus(mem_bus)
  );

  assign mem_bus.wr_en = mem_load_en;
  assign mem_bus.wr_addr = mem_load_addr;
  assign mem_bus.wr_data = mem_load_data;

  // ************************************************************
  // Link resets
  // ************************************************************
  // Frame state is cleared by chip select itself, since sck stands still between frames
  logic frame_rst;
  logic link_rst;
  assign frame_rst = cs_n | ~rst_n;
  assign link_rst = ~rst_n;

  // ************************************************************
  // Configuration into the link domain
  // ************************************************************
  logic [3:0] cfg_s1;
  logic [3:0] cfg_s2;
  logic [3:0] next_cfg_s1;
  logic [3:0] next_cfg_s2;
  logic cfg_quad_en;
  logic cfg_four_byte;
  logic [1:0] cfg_lc;

  always_comb
  begin
    next_cfg_s1 = {first_configuration_register[QIO_CFG_LC_LSB+1:QIO_CFG_LC_LSB],
                   four_byte_address_select,
                   first_configuration_register[QIO_CFG_QUAD_BIT]};
    next_cfg_s2 = cfg_s1;
  end

  always_ff @(posedge sck or posedge link_rst)
  begin
    if (link_rst)
    begin
      cfg_s1 <= 4'h0;
      cfg_s2 <= 4'h0;
    end
    else
    begin
      cfg_s1 <= next_cfg_s1;
      cfg_s2 <= next_cfg_s2;
    end
  end

  assign cfg_quad_en = cfg_s2[0];
  assign cfg_four_byte = cfg_s2[1];
  assign cfg_lc = cfg_s2[3:2];

  // ************************************************************
  // Persistent and per-frame link state
  // ************************************************************
  logic cont;
  logic wide;
  logic next_cont;
  logic next_wide;
  qio_phase_e state;
  logic [3:0] cnt;
  logic [7:0] cmd;
  logic [31:0] addr;
  logic [3:0] mode_hi;
  logic [7:0] cmd_shift;
  logic cmd_done;
  logic cmd_accept;
  logic cmd_wide;
  logic mode_done;
  logic [3:0] addr_cycles;
  logic [3:0] dummy_cycles;

  assign cmd_shift = {cmd[6:0], quad_data_in[0]};
  assign cmd_done = (state == QIO_CMD) && (cnt == QIO_CMD_CYCLES - 4'h1);
  assign cmd_accept = cmd_done && cfg_quad_en &&
                      ((cmd_shift == QIO_CMD_QUAD_IO_READ) ||
                       (cmd_shift == QIO_CMD_QUAD_IO_READ_WIDE_ADDR));
  assign cmd_wide = (cmd_shift == QIO_CMD_QUAD_IO_READ_WIDE_ADDR) || cfg_four_byte;
  assign mode_done = (state == QIO_MODE) && (cnt == QIO_MODE_CYCLES - 4'h1);
  assign addr_cycles = wide ? QIO_ADDR_CYCLES_4B : QIO_ADDR_CYCLES_3B;

  always_comb
  begin
    case (cfg_lc)
      2'b00: dummy_cycles = QIO_DUMMY_LC00;
      2'b01: dummy_cycles = QIO_DUMMY_LC01;
      2'b10: dummy_cycles = QIO_DUMMY_LC10;
      default: dummy_cycles = QIO_DUMMY_LC11;
    endcase
  end

  always_comb
  begin
    next_cont = cont;
    next_wide = wide;
    if (state == QIO_IDLE)
    begin
      // Cleared at frame start; only a completed mode field sets it again
      next_cont = 1'b0;
    end
    if (mode_done)
    begin
      next_cont = (mode_hi == QIO_MODE_CONT_NIBBLE);
    end
    if (cmd_accept)
    begin
      next_wide = cmd_wide;
    end
  end

  always_ff @(posedge sck or posedge link_rst)
  begin
    if (link_rst)
    begin
      cont <= 1'b0;
      wide <= 1'b0;
    end
    else
    begin
      cont <= next_cont;
      wide <= next_wide;
    end
  end

  // ************************************************************
  // Phase sequencer, rising edge
  // ************************************************************
  qio_phase_e next_state;
  logic [3:0] next_cnt;
  logic [7:0] next_cmd;
  logic [31:0] next_addr;
  logic [3:0] next_mode_hi;

  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    next_cmd = cmd;
    next_addr = addr;
    next_mode_hi = mode_hi;
    case (state)
      QIO_IDLE:
      begin
        if (cont)
        begin
          next_addr = {28'h000_0000, quad_data_in};
          next_cnt = 4'h1;
          next_state = QIO_ADDR;
        end
        else
        begin
          next_cmd = {7'h00, quad_data_in[0]};
          next_cnt = 4'h1;
          next_state = QIO_CMD;
        end
      end
      QIO_CMD:
      begin
        next_cmd = cmd_shift;
        next_cnt = cnt + 4'h1;
        if (cmd_done)
        begin
          next_cnt = 4'h0;
          next_state = cmd_accept ? QIO_ADDR : QIO_IGNORE;
        end
      end
      QIO_ADDR:
      begin
        next_addr = {addr[27:0], quad_data_in};
        next_cnt = cnt + 4'h1;
        if (next_cnt == addr_cycles)
        begin
          next_cnt = 4'h0;
          next_state = QIO_MODE;
        end
      end
      QIO_MODE:
      begin
        next_cnt = cnt + 4'h1;
        if (cnt == 4'h0)
        begin
          next_mode_hi = quad_data_in;
        end
        if (mode_done)
        begin
          next_cnt = 4'h0;
          next_state = (dummy_cycles == 4'h0) ? QIO_DATA : QIO_DUMMY;
        end
      end
      QIO_DUMMY:
      begin
        // Lines are not looked at here, so a floating bus does no harm
        next_cnt = cnt + 4'h1;
        if (next_cnt == dummy_cycles)
        begin
          next_cnt = 4'h0;
          next_state = QIO_DATA;
        end
      end
      QIO_DATA: next_state = QIO_DATA;
      QIO_IGNORE: next_state = QIO_IGNORE;
      default: next_state = QIO_IGNORE;
    endcase
  end

  always_ff @(posedge sck or posedge frame_rst)
  begin
    if (frame_rst)
    begin
      state <= QIO_IDLE;
      cnt <= QIO_CNT_RST;
      cmd <= QIO_CMD_RST;
      addr <= QIO_ADDR_RST;
      mode_hi <= QIO_NIBBLE_RST;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      cmd <= next_cmd;
      addr <= next_addr;
      mode_hi <= next_mode_hi;
    end
  end

  // ************************************************************
  // Data output, falling edge
  // ************************************************************
  logic started;
  logic low_half;
  logic drive;
  logic [3:0] dout;
  logic [QIO_MEM_ADDR_W-1:0] ptr;
  logic next_started;
  logic next_low_half;
  logic next_drive;
  logic [3:0] next_dout;
  logic [QIO_MEM_ADDR_W-1:0] next_ptr;

  assign mem_bus.rd_addr = started ? ptr : addr[QIO_MEM_ADDR_W-1:0];

  always_comb
  begin
    next_started = started;
    next_low_half = low_half;
    next_drive = drive;
    next_dout = dout;
    next_ptr = ptr;
    if (state == QIO_DATA)
    begin
      next_drive = 1'b1;
      if (!started || !low_half)
      begin
        next_started = 1'b1;
        next_ptr = mem_bus.rd_addr;
        next_dout = mem_bus.rd_data[7:4];
        next_low_half = 1'b1;
      end
      else
      begin
        next_dout = mem_bus.rd_data[3:0];
        next_low_half = 1'b0;
        // Pointer width equals the array, so the top address rolls over to zero
        next_ptr = ptr + {{(QIO_MEM_ADDR_W-1){1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(negedge sck or posedge frame_rst)
  begin
    if (frame_rst)
    begin
      started <= 1'b0;
      low_half <= 1'b0;
      drive <= 1'b0;
      dout <= QIO_NIBBLE_RST;
      ptr <= {QIO_MEM_ADDR_W{1'b0}};
    end
    else
    begin
      started <= next_started;
      low_half <= next_low_half;
      drive <= next_drive;
      dout <= next_dout;
      ptr <= next_ptr;
    end
  end

  // The host must be off the lines by now; we never drive before the data phase
  assign quad_data_out = dout;
  assign quad_data_oe_n = {4{~drive}};

  // ************************************************************
  // Status into the system clock domain
  // ************************************************************
  logic [1:0] sync_s1;
  logic [1:0] sync_s2;
  logic [1:0] next_sync_s1;
  logic [1:0] next_sync_s2;

  always_comb
  begin
    next_sync_s1 = {cont, ~cs_n};
    next_sync_s2 = sync_s1;
    if (!rst_n)
    begin
      next_sync_s1 = 2'h0;
      next_sync_s2 = 2'h0;
    end
  end

  always_ff @(posedge clk)
  begin
    sync_s1 <= next_sync_s1;
    sync_s2 <= next_sync_s2;
  end

  assign frame_active = sync_s2[0];
  assign continuous_mode = sync_s2[1];

endmodule : qio_read_top

// file: verification/qio_host_model.sv
`timescale 1ns/1ns
module qio_host_model (
  output logic sck,
  output logic cs_n,
  output logic [3:0] host_out,
  output logic host_oe_n,
  input wire logic [3:0] bus
);
  logic [3:0] rd_q[$];

  initial
  begin
    sck = 1'b0;
    cs_n = 1'b1;
    host_out = 4'h0;
    host_oe_n = 1'b1;
  end

  // **********
  // Serial cycles
  // **********
  // Clock stands low between frames; data changes only while low
  task automatic cyc(input logic [3:0] v, input logic drv);
    host_out = v;
    host_oe_n = !drv;
    #32 sck = 1'b1;
    rd_q.push_back(bus);
    #32 sck = 1'b0;
  endtask : cyc

  task automatic frame(input logic [7:0] cmd, input int nc, input logic [31:0] adr,
    input int na, input logic [7:0] mode, input int nd, input int nr);
    cs_n = 1'b0;
    #7;
    for (int i = 7; i > 7 - nc; i--)
      cyc({3'h0, cmd[i]}, 1'b1);
    for (int i = na - 1; i >= 0; i--)
      cyc(adr[4*i+:4], 1'b1);
    cyc(mode[7:4], 1'b1);
    cyc(mode[3:0], 1'b0);
    repeat (nd) cyc(4'h0, 1'b0);
    rd_q.delete();
    repeat (nr) cyc(4'h0, 1'b0);
    // Raised only in the data phase, never in mode or dummy
    #16 cs_n = 1'b1;
    #64;
  endtask : frame

  task automatic short_frame(input int n);
    cs_n = 1'b0;
    #7;
    repeat (n) cyc(4'hF, 1'b1);
    host_oe_n = 1'b1;
    #16 cs_n = 1'b1;
    #64;
  endtask : short_frame
endmodule : qio_host_model

// file: verification/qio_read_chk.sv
`timescale 1ns/1ns
module qio_read_chk
  import qio_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic [3:0] quad_data_out,
  input wire logic [3:0] quad_data_oe_n,
  input wire logic [7:0] first_configuration_register,
  input wire logic frame_active,
  input wire logic continuous_mode
);
  // **********
  // Link checks
  // **********
  default clocking dclk @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  oe_lanes_a: assert property (quad_data_oe_n == 4'h0 || quad_data_oe_n == 4'hF)
    else $error("Output enable lanes differ");
  fall_only_a: assert property (
    $changed(quad_data_out) && !cs_n && !quad_data_oe_n[0] |-> !sck)
    else $error("Data changed while serial clock high");
  quad_off_a: assert property (
    !first_configuration_register[QIO_CFG_QUAD_BIT] |-> quad_data_oe_n == 4'hF)
    else $error("Lines driven with quad disabled");
  drive_start_a: assert property ($fell(quad_data_oe_n[0]) |-> !cs_n && !sck)
    else $error("Drive began outside a falling edge");
  cs_float_a: assert property (cs_n |-> quad_data_oe_n == 4'hF)
    else $error("Lines driven while deselected");
  cont_quad_a: assert property (
    $rose(continuous_mode) |-> first_configuration_register[QIO_CFG_QUAD_BIT])
    else $error("Continuous mode without quad enable");
  cont_frame_a: assert property ($rose(continuous_mode) |-> frame_active)
    else $error("Continuous mode set outside a frame");
  frame_off_a: assert property ($rose(cs_n) |-> ##[2:3] !frame_active)
    else $error("Frame status did not drop");
endmodule : qio_read_chk

// file: verification/qio_read_top_test.sv
`timescale 1ns/1ns
module qio_read_top_test;
  import qio_pkg::*;
  logic clk, rst_n, sck, cs_n, host_oe_n, sel4, ld_en, drove, frame_active, continuous_mode;
  logic [3:0] quad_data_in, quad_data_out, oe_n, host_out, last_bus;
  logic [7:0] cfg, ld_data;
  logic [QIO_MEM_ADDR_W-1:0] ld_addr;
  int num_errors = 0;
  int compares = 0;
  logic [3:0] dly [4] = '{QIO_DUMMY_LC00, QIO_DUMMY_LC01, QIO_DUMMY_LC10, QIO_DUMMY_LC11};

  qio_read_top dut_u (.clk(clk), .rst_n(rst_n), .sck(sck), .cs_n(cs_n),
    .quad_data_in(quad_data_in), .quad_data_out(quad_data_out), .quad_data_oe_n(oe_n),
    .first_configuration_register(cfg), .four_byte_address_select(sel4),
    .mem_load_en(ld_en), .mem_load_addr(ld_addr), .mem_load_data(ld_data),
    .frame_active(frame_active), .continuous_mode(continuous_mode));
  qio_host_model host_u (.sck(sck), .cs_n(cs_n), .host_out(host_out),
    .host_oe_n(host_oe_n), .bus(quad_data_in));

  // **********
  // Wire and clock
  // **********
  // Undriven lines toggle so a stale value never reads as data
  assign quad_data_in = (oe_n[0] === 1'b0) ? quad_data_out :
    (host_oe_n === 1'b0) ? host_out : ~last_bus;
  always @(posedge sck) last_bus <= quad_data_in;
  always @(posedge clk) if (oe_n !== 4'hF) drove <= 1'b1;

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [7:0] mdat(input int a);
    logic [9:0] m;
    m = a[9:0];
    return m[7:0] ^ {m[9:8], m[9:8], 4'h6};
  endfunction : mdat

  task automatic rd_chk(input int a, input int n);
    logic [7:0] e;
    for (int i = 0; i < n; i++)
    begin
      e = mdat(a + i / 2);
      chk(host_u.rd_q[i], (i % 2) ? e[3:0] : e[7:4]);
    end
  endtask : rd_chk

  task automatic setup(input logic q, input logic [1:0] lc, input logic s);
    @(negedge clk);
    cfg = {lc, 4'h0, q, 1'b0};
    sel4 = s;
    #7;
  endtask : setup

  task automatic cont(input logic e);
    repeat (4) @(negedge clk);
    chk(continuous_mode, e);
    chk(frame_active, 1'b0);
  endtask : cont

  // **********
  // Scenarios
  // **********
  task automatic t_basic;
    setup(1'b1, 2'b11, 1'b0);
    // Status is looked at well inside the frame, clear of its sync latency
    fork
      host_u.frame(QIO_CMD_QUAD_IO_READ, 8, 32'h00ABC3FE, 6, 8'h00, dly[3], 9);
      begin
        repeat (30) @(negedge clk);
        chk(frame_active, 1'b1);
      end
    join
    rd_chk(32'h3FE, 9);
    cont(1'b0);
    $display("test basic done");
  endtask : t_basic

  task automatic t_wide;
    for (int lc = 0; lc < 4; lc++)
    begin
      setup(1'b1, lc[1:0], lc[0]);
      host_u.frame(lc[0] ? QIO_CMD_QUAD_IO_READ : QIO_CMD_QUAD_IO_READ_WIDE_ADDR, 8,
        32'hFFFFF000 + 37 * lc, 8, 8'hA5, dly[lc], 6);
      rd_chk(37 * lc, 6);
      cont(1'b1);
      host_u.frame(8'h00, 0, 32'h100 + lc, 8, 8'h5A, dly[lc], 4);
      rd_chk(32'h100 + lc, 4);
      cont(1'b0);
    end
    $display("test wide done");
  endtask : t_wide

  task automatic t_short;
    setup(1'b1, 2'b10, 1'b0);
    host_u.frame(QIO_CMD_QUAD_IO_READ, 8, 32'h200, 6, 8'hAF, dly[2], 2);
    cont(1'b1);
    host_u.short_frame(4);
    cont(1'b0);
    host_u.frame(QIO_CMD_QUAD_IO_READ, 8, 32'h55, 6, 8'h00, dly[2], 4);
    rd_chk(32'h55, 4);
    $display("test short done");
  endtask : t_short

  task automatic t_refuse;
    setup(1'b0, 2'b11, 1'b0);
    drove = 1'b0;
    host_u.frame(QIO_CMD_QUAD_IO_READ, 8, 32'h0, 6, 8'hA0, dly[3], 4);
    setup(1'b1, 2'b11, 1'b0);
    host_u.frame(8'h6B, 8, 32'h0, 6, 8'hA0, dly[3], 4);
    chk(drove, 1'b0);
    cont(1'b0);
    $display("test refuse done");
  endtask : t_refuse

  task automatic print_verdict;
    $display("errors=%0d compares=%0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : print_verdict

  initial
  begin
    rst_n = 1'b0;
    cfg = 8'h00;
    sel4 = 1'b0;
    ld_en = 1'b0;
    ld_addr = '0;
    ld_data = 8'h00;
    drove = 1'b0;
    last_bus = 4'h5;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    for (int a = 0; a < QIO_MEM_DEPTH; a++)
    begin
      ld_en = 1'b1;
      ld_addr = a[QIO_MEM_ADDR_W-1:0];
      ld_data = mdat(a);
      @(negedge clk);
    end
    ld_en = 1'b0;
    t_basic();
    t_wide();
    t_short();
    t_refuse();
    print_verdict();
  end

  // Run needs about 40 us; this cuts a hang
  initial
  begin
    #400000;
    num_errors++;
    print_verdict();
  end
endmodule : qio_read_top_test

bind qio_read_top qio_read_chk chk_u (.clk(clk), .rst_n(rst_n), .sck(sck), .cs_n(cs_n),
  .quad_data_out(quad_data_out), .quad_data_oe_n(quad_data_oe_n),
  .first_configuration_register(first_configuration_register),
  .frame_active(frame_active), .continuous_mode(continuous_mode));
